// ---- core/dpc_pin_block.sv ----
// four-cell dual-edge pin register block with wishbone config and capture fifo
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module dpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic             doPush;
  logic             doPop;
  assign inReady  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (level != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush & ~doPop) begin
        level <= level + 1'b1;
      end else if (doPop & ~doPush) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

module dpc_pin_block
  import dpc_pkg::*;
#(
  parameter logic [CELLS-1:0] POWERUP_HIGH = 4'h0
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  input  wire dpc_core_s            coreLines,
  input  wire logic [IO_CLKS-1:0]   ioClk,
  output logic [CELLS-1:0]          coreInHigh,
  output logic [CELLS-1:0]          coreInLow,
  input  wire logic [CELLS-1:0]     padIn,
  output logic [CELLS-1:0]          padOut,
  output logic [CELLS-1:0]          padOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  if (FIFO_WIDTH != 2 * CELLS) begin : g_chkWidth
    $error("capture fifo width must hold both bits of every cell");
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] s, input logic inv);
    return v[s] ^ inv;
  endfunction
  function automatic logic pickClk(input logic [7:0] io, input logic [3:0] cl, input logic [3:0] s);
    return (s < CLK_SRC_IO) ? io[s[2:0]] : cl[s[1:0]];
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction
  // ----------------------------------------
  // bus slave and config
  // ----------------------------------------
  dpc_cfg_s                        cfg [CELLS];
  logic                            req;
  logic                            ovf;
  logic                            fifoReady;
  logic                            fifoValid;
  logic [FIFO_WIDTH-1:0]           fifoData;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel;
  logic                            pushPend;
  logic                            pop;
  logic                            blocked;
  logic [CELLS-1:0]                inRise, inFall, outRise, outFall, clkInLvl, clkOutLvl;
  logic [CELLS-1:0]                prevIn, prevOut, ceInE, ceOutE, aclrE, sclrE, oeE, padE;
  logic [CELLS-1:0]                dA, dB, setV, stall, inA, inB, latB, outA, outB, oeR, oeNeg;
  assign req = cyc_i & stb_i & ~ack_o;
  assign pop = req & ~we_i & (adr_i == ADR_FIFO) & fifoValid;
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end
  for (genvar c = 0; c < CELLS; c++) begin : g_cfg
    always_ff @(posedge clk) begin
      if (rst) begin
        cfg[c]           <= '0;
        cfg[c].presetSel <= POWERUP_HIGH[c];
      end else if (req & we_i & (adr_i == ADR_CFG0 + 8'(4 * c))) begin
        cfg[c] <= dpc_cfg_s'(merge(32'(cfg[c]), dat_i, sel_i) & {{(32-CFG_BITS){1'b0}}, {CFG_BITS{1'b1}}});
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf <= 1'b0;
    end else if (blocked) begin
      ovf <= 1'b1;
    end else if (req & we_i & sel_i[0] & (adr_i == ADR_STATUS) & dat_i[ST_OVF]) begin
      ovf <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_o <= 32'h00000000;
    end else if (req & ~we_i) begin
      dat_o <= 32'h00000000;
      if (adr_i < ADR_STATUS && adr_i[1:0] == 2'h0) begin
        dat_o <= 32'(cfg[adr_i[3:2]]);
      end else if (adr_i == ADR_STATUS) begin
        dat_o[ST_OVF]                      <= ovf;
        dat_o[ST_NE]                       <= fifoValid;
        dat_o[ST_LVL +: $bits(fifoLevel)] <= fifoLevel;
      end else if (adr_i == ADR_FIFO && fifoValid) begin
        dat_o[FIFO_WIDTH-1:0] <= fifoData;
      end
    end
  end
  // ----------------------------------------
  // capture fifo
  // ----------------------------------------
  assign blocked = cfg[0].fifoEn & inRise[0] & ceInE[0] & ~fifoReady;
  always_ff @(posedge clk) begin
    if (rst) begin
      pushPend <= 1'b0;
    end else begin
      pushPend <= cfg[0].fifoEn & inRise[0] & ceInE[0] & ~stall[0] & ~aclrE[0];
    end
  end
  dpc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushPend),
    .inReady  (fifoReady),
    .inData   ({latB, inA}),
    .outValid (fifoValid),
    .outReady (pop),
    .outData  (fifoData),
    .level    (fifoLevel)
  );
  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  for (genvar g = 0; g < CELLS; g++) begin : g_cell
    logic ddrIn, ddrOut, bidir;
    assign ddrIn  = (cfg[g].mode == MODE_DDR_IN) | (cfg[g].mode == MODE_BIDIR);
    assign ddrOut = (cfg[g].mode == MODE_DDR_OU) | (cfg[g].mode == MODE_BIDIR);
    assign bidir  = (cfg[g].mode == MODE_BIDIR);
    // per-cell selection and inversion
    assign clkInLvl[g]  = pickClk(ioClk, coreLines.clk, cfg[g].clkInSel);
    assign clkOutLvl[g] = pickClk(ioClk, coreLines.clk, cfg[g].clkOutSel);
    assign ceInE[g]  = pick4(coreLines.ceIn, cfg[g].ceInSel, cfg[g].invert[INV_CEI]);
    assign ceOutE[g] = pick4(coreLines.ceOut, cfg[g].ceOutSel, cfg[g].invert[INV_CEO]);
    assign aclrE[g]  = pick4(coreLines.aclr, cfg[g].aclrSel, cfg[g].invert[INV_ACLR]);
    assign sclrE[g]  = pick4(coreLines.sclr, cfg[g].sclrSel, cfg[g].invert[INV_SCLR]);
    assign oeE[g]    = pick4(coreLines.oe, cfg[g].oeSel, cfg[g].invert[INV_OE]);
    assign dA[g]     = coreLines.dataA[g] ^ cfg[g].invert[INV_A];
    assign dB[g]     = coreLines.dataB[g] ^ cfg[g].invert[INV_B];
    assign padE[g]   = padIn[g] ^ cfg[g].invert[INV_PAD];
    assign setV[g]   = cfg[g].presetSel;
    assign stall[g]  = cfg[g].fifoEn & ~fifoReady;
    assign inRise[g]  = clkInLvl[g] & ~prevIn[g];
    assign inFall[g]  = ~clkInLvl[g] & prevIn[g];
    assign outRise[g] = clkOutLvl[g] & ~prevOut[g];
    assign outFall[g] = ~clkOutLvl[g] & prevOut[g];
    // previous levels track through reset, so no false edge follows it
    always_ff @(posedge clk) begin
      prevIn[g]  <= clkInLvl[g];
      prevOut[g] <= clkOutLvl[g];
    end
    // input side
    always_ff @(posedge clk) begin
      if (rst) begin
        inA[g]  <= POWERUP_HIGH[g];
        inB[g]  <= POWERUP_HIGH[g];
        latB[g] <= POWERUP_HIGH[g];
      end else if (aclrE[g]) begin
        inA[g]  <= setV[g];
        inB[g]  <= setV[g];
        latB[g] <= setV[g];
      end else if (inRise[g] & ceInE[g] & ~stall[g]) begin
        if (sclrE[g]) begin
          inA[g]  <= setV[g];
          latB[g] <= setV[g];
        end else begin
          inA[g]  <= padE[g];
          latB[g] <= inB[g];
        end
      end else if (ddrIn & inFall[g] & ceInE[g] & ~stall[g]) begin
        inB[g] <= sclrE[g] ? setV[g] : padE[g];
      end
    end
    assign coreInHigh[g] = latB[g];
    assign coreInLow[g]  = inA[g];
    // output side, one clock and gate for data and enable
    always_ff @(posedge clk) begin
      if (rst) begin
        outA[g] <= POWERUP_HIGH[g];
        outB[g] <= POWERUP_HIGH[g];
        oeR[g]  <= POWERUP_HIGH[g];
      end else if (aclrE[g]) begin
        outA[g] <= setV[g];
        outB[g] <= setV[g];
        oeR[g]  <= setV[g];
      end else if (outRise[g] & ceOutE[g]) begin
        outA[g] <= sclrE[g] ? setV[g] : dA[g];
        outB[g] <= sclrE[g] ? setV[g] : dB[g];
        oeR[g]  <= sclrE[g] ? setV[g] : ~oeE[g];
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        oeNeg[g] <= POWERUP_HIGH[g];
      end else if (aclrE[g]) begin
        oeNeg[g] <= setV[g];
      end else if (outFall[g] & ceOutE[g]) begin
        oeNeg[g] <= sclrE[g] ? setV[g] : oeR[g];
      end
    end
    assign padOut[g] = (ddrOut & ~clkOutLvl[g]) ? outB[g] : outA[g];
    assign padOe[g]  = bidir ? (~oeR[g] & ~oeNeg[g]) : ~oeR[g];
    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_aclr;
      aclrE[g] |=> (inA[g] == $past(setV[g])) && (outA[g] == $past(setV[g])) && (oeR[g] == $past(setV[g]));
    endproperty
    a_aclr: assert property (p_aclr) else $error("clear did not force cell");
    property p_sclr;
      !aclrE[g] && outRise[g] && ceOutE[g] && sclrE[g] |=> outB[g] == $past(setV[g]);
    endproperty
    a_sclr: assert property (p_sclr) else $error("sync clear ignored");
    property p_hold;
      !aclrE[g] && !(outRise[g] && ceOutE[g]) |=> $stable(outA[g]) && $stable(oeR[g]);
    endproperty
    a_hold: assert property (p_hold) else $error("output changed without enabled edge");
    property p_inRise;
      !aclrE[g] && inRise[g] && ceInE[g] && !stall[g] && !sclrE[g] |=> inA[g] == $past(padE[g]);
    endproperty
    a_inRise: assert property (p_inRise) else $error("rising capture wrong");
    property p_inFall;
      !aclrE[g] && ddrIn && inFall[g] && ceInE[g] && !stall[g] && !sclrE[g] |=> inB[g] == $past(padE[g]);
    endproperty
    a_inFall: assert property (p_inFall) else $error("falling capture wrong");
    property p_latch;
      !aclrE[g] && inRise[g] && ceInE[g] && !stall[g] && !sclrE[g] |=> coreInHigh[g] == $past(inB[g]);
    endproperty
    a_latch: assert property (p_latch) else $error("latched bit not aligned");
    property p_ddrOut;
      !aclrE[g] && ddrOut && outRise[g] && ceOutE[g] && !sclrE[g] ##1 clkOutLvl[g] |-> padOut[g] == $past(dA[g]);
    endproperty
    a_ddrOut: assert property (p_ddrOut) else $error("high phase bit wrong");
    property p_ddrLow;
      !aclrE[g] && ddrOut && outRise[g] && ceOutE[g] && !sclrE[g]
        ##1 (!outRise[g] && !aclrE[g] && ddrOut) [*3]
        ##1 (!clkOutLvl[g] && ddrOut) |-> padOut[g] == $past(dB[g], 4);
    endproperty
    a_ddrLow: assert property (p_ddrLow) else $error("low phase bit wrong");
    property p_oeDelay;
      bidir && $past(bidir) && $fell(oeR[g]) && !$past(outFall[g]) && !$past(aclrE[g]) |-> !padOe[g];
    endproperty
    a_oeDelay: assert property (p_oeDelay) else $error("pad driven before falling edge");
    property p_oeLow;
      !aclrE[g] && outRise[g] && ceOutE[g] && !sclrE[g] |=> oeR[g] == !$past(oeE[g]);
    endproperty
    a_oeLow: assert property (p_oeLow) else $error("enable register not active low");
    property p_oeNeg;
      !aclrE[g] && outFall[g] && ceOutE[g] && !sclrE[g] |=> oeNeg[g] == $past(oeR[g]);
    endproperty
    a_oeNeg: assert property (p_oeNeg) else $error("falling enable register not loaded");
    property p_inHold;
      !aclrE[g] && !(inRise[g] && ceInE[g]) && !(ddrIn && inFall[g] && ceInE[g])
        |=> $stable(inA[g]) && $stable(inB[g]) && $stable(latB[g]);
    endproperty
    a_inHold: assert property (p_inHold) else $error("input changed without enabled edge");
    property p_aclrRest;
      aclrE[g] |=> (inB[g] == $past(setV[g])) && (latB[g] == $past(setV[g])) && (outB[g] == $past(setV[g]))
        && (oeNeg[g] == $past(setV[g]));
    endproperty
    a_aclrRest: assert property (p_aclrRest) else $error("clear missed a register");
    c_ddrIn: cover property (ddrIn && inFall[g] && ceInE[g] ##[1:8] inRise[g] && ceInE[g]);
    c_bidir: cover property (bidir && !oeR[g] ##[1:8] padOe[g]);
  end
  property p_ack;
    req |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  c_full: cover property (!fifoReady);
  c_pop: cover property (pop ##1 ack_o);
endmodule

// ---- core/dpc_pkg.sv ----
// constants, carriers and register map of the dual-edge pin block
// Contract
// - each cell has two input registers, a capture latch, two output and two enable registers.
// - one block serves four cells from 32 core lines of data and control.
// - eight block clock lines act as the clock sources of the cell registers.
// - each cell picks its own enable, gates, clear, sync clear and both clocks.
// - input registers may use their own clock and clock gate.
// - output and output-enable registers always share one clock and one gate.
// - all registers of a cell share one clear source; clear or preset per cell.
// - registers power up low with clear or high with preset.
// - a synchronous clear/set is offered besides the asynchronous one.
// - dual-edge input samples on the rising and the falling edge.
// - a latch holds the high-phase bit so both bits leave on one edge.
// - dual-edge output loads both output registers on the rising edge.
// - clock level selects first bit while high, second bit while low.
// - bidirectional dual-edge mode joins the input and output paths.
// - in bidirectional mode a falling-edge enable register delays pad drive.
// - enable register is active low; the core-side enable is active high.
// - every input of a cell can be inverted inside the cell; the code has no inversion bit for the input and output clocks.
package dpc_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int CELLS      = 4;
  localparam int IO_CLKS    = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADR_CFG0   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_FIFO   = 8'h14;
  localparam int         ST_OVF     = 0;
  localparam int         ST_NE      = 1;
  localparam int         ST_LVL     = 4;
  // ----------------------------------------
  // modes, sources, inversion bits
  // ----------------------------------------
  localparam logic [1:0] MODE_SDR    = 2'h0;
  localparam logic [1:0] MODE_DDR_IN = 2'h1;
  localparam logic [1:0] MODE_DDR_OU = 2'h2;
  localparam logic [1:0] MODE_BIDIR  = 2'h3;
  localparam logic [3:0] CLK_SRC_IO  = 4'h8;
  localparam int INV_A = 0, INV_B = 1, INV_OE = 2, INV_CEI = 3;
  localparam int INV_CEO = 4, INV_ACLR = 5, INV_SCLR = 6, INV_PAD = 7;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] dataA;
    logic [3:0] dataB;
    logic [3:0] oe;
    logic [3:0] ceIn;
    logic [3:0] ceOut;
    logic [3:0] clk;
    logic [3:0] aclr;
    logic [3:0] sclr;
  } dpc_core_s;
  typedef struct packed {
    logic       fifoEn;
    logic       presetSel;
    logic [1:0] mode;
    logic [7:0] invert;
    logic [3:0] clkOutSel;
    logic [3:0] clkInSel;
    logic [1:0] sclrSel;
    logic [1:0] aclrSel;
    logic [1:0] oeSel;
    logic [1:0] ceOutSel;
    logic [1:0] ceInSel;
  } dpc_cfg_s;
  localparam int CFG_BITS = $bits(dpc_cfg_s);
endpackage

// ---- sim/dpc_pad_model.sv ----
// pad-side device model sending centre-aligned dual-edge data
`timescale 1ns/1ps
module dpc_pad_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       refClk,
  input  wire logic       drvEn,
  input  wire logic       hiBit,
  input  wire logic       loBit,
  input  wire logic [3:0] padOut,
  input  wire logic [3:0] padOe,
  output logic [3:0]      padIn
);
  // ----------------------------------------
  // data lags the clock so each bit straddles its sampling edge
  // ----------------------------------------
  logic dly1;
  logic dly2;
  logic idleBit;
  always_ff @(posedge clk) begin
    if (rst) begin
      dly1 <= 1'h0;
      dly2 <= 1'h0;
    end else begin
      dly1 <= refClk;
      dly2 <= dly1;
    end
  end
  // released line shows a pattern that changes every cycle
  always_ff @(posedge clk) begin
    idleBit <= rst ? 1'h0 : ~idleBit;
  end
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      padIn[c] = padOe[c] ? padOut[c] : (drvEn ? (dly2 ? hiBit : loBit) : idleBit);
    end
  end
endmodule

// ---- sim/dpc_testbench.sv ----
// self-checking bench of the dual-edge pin block
`timescale 1ns/1ps
module testbench
  import dpc_pkg::*;
();
  logic               clk, rst, cyc, stb, we, ack, hiBit, loBit, drvEn;
  logic [7:0]         adr;
  logic [3:0]         sel, coreInHigh, coreInLow, padIn, padOut, padOe;
  logic [31:0]        wdat, rdat, junk;
  logic [2:0]         divCnt;
  logic [IO_CLKS-1:0] ioClk;
  dpc_core_s          core;
  int                 errors, compares;
  dpc_pin_block dut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .coreLines(core), .ioClk(ioClk), .coreInHigh(coreInHigh),
    .coreInLow(coreInLow), .padIn(padIn), .padOut(padOut), .padOe(padOe));
  dpc_pad_model partner (.clk(clk), .rst(rst), .refClk(ioClk[0]), .drvEn(drvEn), .hiBit(hiBit),
    .loBit(loBit), .padOut(padOut), .padOe(padOe), .padIn(padIn));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // io clock of eight system cycles, four high and four low
  always @(posedge clk) begin
    divCnt <= divCnt + 3'h1;
    ioClk  <= {7'h00, divCnt[2]};
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkPin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic waitPhase(input logic lvl, input int extra);
    int n;
    n = 0;
    while (ioClk[0] === lvl && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (ioClk[0] !== lvl && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      complete_run();
    end
    repeat (extra) @(posedge clk);
  endtask
  function automatic logic [31:0] cfgWord(input logic [1:0] m, input logic [7:0] inv, input logic pre,
                                          input logic fen);
    return {2'h0, fen, pre, m, inv, 18'h00000};
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testReset();
    chkWord({28'h0000000, padOe}, 32'h0000000F);
    chkWord({28'h0000000, padOut}, 32'h00000000);
    rst <= 1'h0;
    for (int a = 0; a < 7; a++) begin
      wbCycle(1'h0, 8'(a == 6 ? 64 : a * 4), 32'h00000000, junk);
      chkWord(junk, 32'h00000000);
    end
    wbCycle(1'h1, ADR_CFG0, 32'hFFFFFFFF, junk);
    wbCycle(1'h0, ADR_CFG0, 32'h00000000, junk);
    chkWord(junk, 32'h3FFFFFFF);
    wbCycle(1'h1, ADR_CFG0, 32'h00000000, junk);
    $display("test reset done");
  endtask
  task automatic testDdrIn();
    for (int k = 0; k < 4; k++) begin
      hiBit <= k[0];
      loBit <= ~k[0];
      wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_DDR_IN, 8'(k[1]) << INV_PAD, 1'h0, 1'h0), junk);
      repeat (3) waitPhase(1'h1, 0);
      waitPhase(1'h1, 2);
      chkPin(coreInHigh[0], k[0] ^ k[1]);
      chkPin(coreInLow[0], ~k[0] ^ k[1]);
    end
    $display("test dual-edge input done");
  endtask
  task automatic testClear();
    hiBit <= 1'h0;
    loBit <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      // one aclr line feeds every register of the cell
      wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_DDR_IN, 8'h00, p[0], 1'h0), junk);
      core.aclr <= 4'h1;
      waitPhase(1'h0, 1);
      waitPhase(1'h1, 2);
      chkPin(coreInHigh[0], p[0]);
      chkPin(coreInLow[0], p[0]);
      chkPin(padOe[0], ~p[0]);
      core.aclr <= 4'h0;
      core.sclr <= 4'h1;
      repeat (2) waitPhase(1'h1, 2);
      chkPin(coreInHigh[0], p[0]);
      core.sclr <= 4'h0;
      repeat (2) waitPhase(1'h1, 2);
      chkPin(coreInHigh[0], 1'h0);
    end
    $display("test clear and preset done");
  endtask
  task automatic testFifo();
    hiBit <= 1'h1;
    wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_DDR_IN, 8'h00, 1'h0, 1'h1), junk);
    repeat (12) waitPhase(1'h1, 0);
    wbCycle(1'h0, ADR_STATUS, 32'h00000000, junk);
    chkWord(junk, 32'h00000083);
    wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_DDR_IN, 8'h00, 1'h0, 1'h0), junk);
    for (int i = 0; i < 9; i++) begin
      wbCycle(1'h0, ADR_FIFO, 32'h00000000, junk);
      chkWord(junk & 32'h00000011, i < 8 ? 32'h00000010 : 32'h00000000);
    end
    wbCycle(1'h0, ADR_STATUS, 32'h00000000, junk);
    chkWord(junk, 32'h00000001);
    wbCycle(1'h1, ADR_STATUS, 32'h00000001, junk);
    wbCycle(1'h0, ADR_STATUS, 32'h00000000, junk);
    chkWord(junk, 32'h00000000);
    $display("test capture buffer done");
  endtask
  task automatic testDdrOut();
    core.dataA <= 4'h0;
    core.dataB <= 4'h1;
    core.oe    <= 4'h1;
    wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_DDR_OU, 8'h00, 1'h0, 1'h0), junk);
    waitPhase(1'h1, 2);
    chkPin(padOe[0], 1'h1);
    chkPin(padOut[0], 1'h0);
    waitPhase(1'h0, 2);
    chkPin(padOut[0], 1'h1);
    core.oe <= 4'h0;
    $display("test dual-edge output done");
  endtask
  task automatic testBidir();
    drvEn      <= 1'h0;
    core.dataA <= 4'h1;
    core.dataB <= 4'h0;
    wbCycle(1'h1, ADR_CFG0, cfgWord(MODE_BIDIR, 8'h00, 1'h0, 1'h0), junk);
    waitPhase(1'h1, 0);
    waitPhase(1'h0, 1);
    chkPin(padOe[0], 1'h0);
    core.oe <= 4'h1;
    waitPhase(1'h1, 2);
    chkPin(padOe[0], 1'h0);
    chkPin(padOut[0], 1'h1);
    waitPhase(1'h0, 2);
    chkPin(padOe[0], 1'h1);
    chkPin(padOut[0], 1'h0);
    core.oe <= 4'h0;
    $display("test bidirectional done");
  endtask
  initial begin
    {rst, cyc, stb, we, hiBit, loBit, drvEn} = 7'h41;
    {adr, wdat, divCnt, ioClk} = 51'h0;
    sel = 4'hF;
    core = '0;
    core.ceIn = 4'hF;
    core.ceOut = 4'hF;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    testReset();
    testDdrIn();
    testClear();
    testFifo();
    testDdrOut();
    testBidir();
    complete_run();
  end
endmodule
